// *** inc/pscg_pkg.sv ***
package pscg_pkg;
    // ****************************************
    // Register byte addresses (low 16 bits)
    // ****************************************
    localparam logic [15:0] PSCG_OSC_CTRL_OFS = 16'hF000;
    localparam logic [15:0] PSCG_MD_ANALOG_OFS = 16'hF240;
    localparam logic [15:0] PSCG_MD_CMP_OFS = 16'hF250;
    localparam logic [15:0] PSCG_MD_CAPCMP_OFS = 16'hF260;
    localparam logic [15:0] PSCG_MD_TIMERS_OFS = 16'hF270;
    localparam logic [15:0] PSCG_MD_SERIAL_OFS = 16'hF280;
    localparam logic [15:0] PSCG_MD_MISC_OFS = 16'hF290;
    localparam logic [15:0] PSCG_STATUS_OFS = 16'hF2A0;
    localparam logic [1:0] PSCG_ALIAS_WRITE = 2'h0;
    localparam logic [1:0] PSCG_ALIAS_CLR = 2'h1;
    localparam logic [1:0] PSCG_ALIAS_SET = 2'h2;
    localparam logic [1:0] PSCG_ALIAS_INV = 2'h3;
    // ****************************************
    // Fields and masks
    // ****************************************
    localparam int PSCG_SLEEP_SEL_BIT = 4;
    localparam int PSCG_DIV_LO = 19;
    localparam int PSCG_DIV_HI = 20;
    localparam logic [31:0] PSCG_OSC_MASK = 32'h00180010;
    localparam logic [31:0] PSCG_MASK_ANALOG = 32'h00001101;
    localparam logic [31:0] PSCG_MASK_CMP = 32'h00000007;
    localparam logic [31:0] PSCG_MASK_CAPCMP = 32'h001F001F;
    localparam logic [31:0] PSCG_MASK_TIMERS = 32'h0000001F;
    localparam logic [31:0] PSCG_MASK_SERIAL = 32'h01030303;
    localparam logic [31:0] PSCG_MASK_MISC = 32'h00010003;
    localparam logic [31:0] PSCG_RESET_VALUE = 32'h00000000;
    localparam int PSCG_NUM_MD = 6;
    localparam int PSCG_PRIO_W = 3;
    // ****************************************
    // Oscillator start-up delay
    // ****************************************
    localparam int PSCG_CLK_MHZ = 25;
    localparam int PSCG_STARTUP_US = 10;
    localparam int PSCG_STARTUP_CYC = PSCG_STARTUP_US * PSCG_CLK_MHZ;
    typedef enum logic [1:0] {PSCG_RUN, PSCG_IDLE, PSCG_SLEEP, PSCG_START} pscg_state_t;
endpackage

// *** core/pscg_top.sv ***
// Summary of operation
// R1 - In Sleep a higher-than-CPU-priority interrupt from a sleep-capable source wakes the CPU.
// R2 - Any reset or a watchdog time-out also ends Sleep.
// R3 - A sleep wake of low priority restarts the peripheral clock and goes to Idle, CPU halted.
// R4 - Idle halts the CPU but keeps the system clock running for peripherals.
// R5 - A peripheral with its stop-in-idle bit set halts in Idle, others keep running.
// R6 - A wait with the sleep-select bit clear enters Idle, otherwise Sleep.
// R7 - In Idle only an interrupt above CPU priority wakes; lower ones leave Idle in place.
// R8 - Any reset or a watchdog time-out interrupt also ends Idle.
// R9 - A two-bit divider sets the peripheral clock ratio to 1:1, 1:2, 1:4 or 1:8.
// R10 - System-clocked blocks get an ungated enable independent of the divider.
// R11 - A peripheral read completes only at the next peripheral clock edge.
// R12 - Leaving Sleep with the crystal or PLL stopped waits for start-up; Idle exit adds none.
// R13 - Module disable registers hold one bit per peripheral and reset to zero.
// R14 - Offsets 0x4, 0x8, 0xC clear, set or invert the written one bits.
// R15 - A set module disable bit gates that peripheral's clock enable off.
`timescale 1ns/1ns
`default_nettype none
module pscg_top #(
    parameter int STARTUP_CYC = pscg_pkg::PSCG_STARTUP_CYC
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [31:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic wait_exec, // Wait instruction pulse
    input wire logic irq_valid, // Enabled interrupt pending
    input wire logic irq_sleep_capable, // Source runs in Sleep
    input wire logic [pscg_pkg::PSCG_PRIO_W-1:0] irq_prio, // Interrupt priority
    input wire logic [pscg_pkg::PSCG_PRIO_W-1:0] cpu_prio, // CPU priority
    input wire logic watchdog_timeout, // Watchdog time-out
    input wire logic osc_needs_startup, // Source uses crystal or PLL
    input wire logic [31:0] stop_in_idle, // Stop-in-idle mask shared by every group
    input wire logic periph_rd_req, // CPU peripheral read pending
    output logic periph_rd_done, // Read may complete
    output logic cpu_run, // CPU clock enable
    output logic main_system_clock_en, // Ungated system clock enable
    output logic periph_bus_clock_en, // Peripheral bus clock edge
    output logic [31:0] periph_clk_en [pscg_pkg::PSCG_NUM_MD], // Per-peripheral enables
    output pscg_pkg::pscg_state_t power_state // Current power state
);
    import pscg_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] osc_ctrl;
    logic [31:0] md [PSCG_NUM_MD];
    logic [2:0] div_cnt;
    logic [$clog2(STARTUP_CYC+1)-1:0] start_cnt;
    pscg_state_t next_state;
    logic wake_hi, ev_reset_like, pb_tick;
    logic [2:0] div_mask;
    logic wake_pend;

    function automatic logic [31:0] md_mask(input int i);
        case (i)
            0: md_mask = PSCG_MASK_ANALOG;
            1: md_mask = PSCG_MASK_CMP;
            2: md_mask = PSCG_MASK_CAPCMP;
            3: md_mask = PSCG_MASK_TIMERS;
            4: md_mask = PSCG_MASK_SERIAL;
            default: md_mask = PSCG_MASK_MISC;
        endcase
    endfunction

    function automatic logic [15:0] md_base(input int i);
        case (i)
            0: md_base = PSCG_MD_ANALOG_OFS;
            1: md_base = PSCG_MD_CMP_OFS;
            2: md_base = PSCG_MD_CAPCMP_OFS;
            3: md_base = PSCG_MD_TIMERS_OFS;
            4: md_base = PSCG_MD_SERIAL_OFS;
            default: md_base = PSCG_MD_MISC_OFS;
        endcase
    endfunction

    function automatic logic [31:0] alias_op(input logic [31:0] cur, input logic [31:0] wd,
                                              input logic [1:0] op, input logic [31:0] msk);
        case (op)
            PSCG_ALIAS_CLR: alias_op = cur & ~wd;
            PSCG_ALIAS_SET: alias_op = cur | (wd & msk);
            PSCG_ALIAS_INV: alias_op = cur ^ (wd & msk);
            default: alias_op = wd & msk;
        endcase
    endfunction

    wire logic wr_acc = psel && penable && pwrite;
    wire logic [1:0] op = paddr[3:2];
    wire logic [15:0] base = {paddr[15:4], 4'h0};

    // ****************************************
    // Register writes
    // ****************************************
    // Aliases work on the oscillator control register too
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_ctrl <= PSCG_RESET_VALUE;
        end else if (wr_acc && base == PSCG_OSC_CTRL_OFS) begin
            osc_ctrl <= alias_op(osc_ctrl, pwdata, op, PSCG_OSC_MASK);
        end
    end

    // R13 reset zero
    // R14 alias writes
    always_ff @(posedge clk) begin
        for (int i = 0; i < PSCG_NUM_MD; i++) begin
            if (rst) begin
                md[i] <= PSCG_RESET_VALUE;
            end else if (wr_acc && base == md_base(i)) begin
                md[i] <= alias_op(md[i], pwdata, op, md_mask(i));
            end
        end
    end

    // ****************************************
    // APB read and answer
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Zero wait states: ready follows the setup cycle
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                pslverr <= 1'b1;
                if (base == PSCG_OSC_CTRL_OFS) begin
                    prdata <= osc_ctrl;
                    pslverr <= 1'b0;
                end
                if (paddr[15:0] == PSCG_STATUS_OFS) begin
                    prdata <= {30'h00000000, power_state};
                    pslverr <= 1'b0;
                end
                for (int i = 0; i < PSCG_NUM_MD; i++) begin
                    if (base == md_base(i)) begin
                        prdata <= md[i];
                        pslverr <= 1'b0;
                    end
                end
                if (pwrite && paddr[15:0] == PSCG_STATUS_OFS) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Peripheral bus divider
    // ****************************************
    // R9 divider ratio
    always_comb begin
        case (osc_ctrl[PSCG_DIV_HI:PSCG_DIV_LO])
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    end

    assign pb_tick = (div_cnt & div_mask) == div_mask;

    // Counter restarts so the first tick after Sleep is a full period
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt <= 3'h0;
        end else if (next_state == PSCG_SLEEP || next_state == PSCG_START) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= (pb_tick) ? 3'h0 : div_cnt + 3'h1;
        end
    end

    // ****************************************
    // Power state machine
    // ****************************************
    assign wake_hi = irq_valid && (irq_prio > cpu_prio);
    assign ev_reset_like = watchdog_timeout;

    always_comb begin
        next_state = power_state;
        case (power_state)
            PSCG_RUN: begin
                // R6 wait entry
                if (wait_exec) begin
                    next_state = osc_ctrl[PSCG_SLEEP_SEL_BIT] ? PSCG_SLEEP : PSCG_IDLE;
                end
            end
            PSCG_IDLE: begin
                // R7 idle wake
                // R8 watchdog exit
                if (wake_hi || ev_reset_like) begin
                    next_state = PSCG_RUN;
                end
            end
            PSCG_SLEEP: begin
                // R1 sleep wake
                // R2 watchdog exit
                // R3 low priority to idle
                // R12 startup delay
                if ((irq_valid && irq_sleep_capable) || ev_reset_like) begin
                    if (osc_needs_startup && STARTUP_CYC > 0) begin
                        next_state = PSCG_START;
                    end else if (wake_hi || ev_reset_like) begin
                        next_state = PSCG_RUN;
                    end else begin
                        next_state = PSCG_IDLE;
                    end
                end
            end
            PSCG_START: begin
                // R12 start-up done
                // R1 held wake cause
                if (start_cnt == '0) begin
                    next_state = (wake_pend || wake_hi || ev_reset_like) ? PSCG_RUN : PSCG_IDLE;
                end
            end
            default: next_state = PSCG_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            power_state <= PSCG_RUN;
        end else begin
            power_state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            start_cnt <= '0;
        end else if (power_state == PSCG_SLEEP) begin
            start_cnt <= $bits(start_cnt)'(STARTUP_CYC - 1);
        end else if (start_cnt != '0) begin
            start_cnt <= start_cnt - 1'b1;
        end
    end

    // ****************************************
    // Wake cause held through start-up
    // ****************************************
    // Interrupt and watchdog may be short pulses;
    // the start-up wait must not lose which one woke the device
    // R1 priority wake kept
    // R2 watchdog wake kept
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_pend <= 1'b0;
        end else if (power_state == PSCG_SLEEP) begin
            wake_pend <= wake_hi || ev_reset_like;
        end
    end

    // ****************************************
    // Clock enables
    // ****************************************
    // R4 idle halts cpu
    // R10 system clock domain
    // R11 read on pb edge
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_run <= 1'b1;
            main_system_clock_en <= 1'b1;
            periph_bus_clock_en <= 1'b0;
            periph_rd_done <= 1'b0;
        end else begin
            cpu_run <= next_state == PSCG_RUN;
            main_system_clock_en <= next_state != PSCG_SLEEP && next_state != PSCG_START;
            periph_bus_clock_en <= pb_tick && (next_state == PSCG_RUN || next_state == PSCG_IDLE);
            periph_rd_done <= periph_rd_req && pb_tick && next_state == PSCG_RUN;
        end
    end

    // One stop-in-idle mask is shared by every group
    // R5 stop in idle
    // R15 module gating
    always_ff @(posedge clk) begin
        for (int i = 0; i < PSCG_NUM_MD; i++) begin
            if (rst) begin
                periph_clk_en[i] <= 32'h00000000;
            end else if (pb_tick && (next_state == PSCG_RUN || next_state == PSCG_IDLE)) begin
                periph_clk_en[i] <= md_mask(i) & ~md[i]
                    & ((next_state == PSCG_IDLE) ? ~stop_in_idle : 32'hFFFFFFFF);
            end else begin
                periph_clk_en[i] <= 32'h00000000;
            end
        end
    end
endmodule
`default_nettype wire

// *** test/pscg_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module pscg_properties #(
    parameter int STARTUP_CYC = 4
) (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pready, // Ready
    input wire logic wait_exec, // Wait
    input wire logic irq_valid, // Irq
    input wire logic irq_sleep_capable, // Sleep source
    input wire logic [pscg_pkg::PSCG_PRIO_W-1:0] irq_prio, // Irq priority
    input wire logic [pscg_pkg::PSCG_PRIO_W-1:0] cpu_prio, // Cpu priority
    input wire logic watchdog_timeout, // Watchdog
    input wire logic osc_needs_startup, // Start-up
    input wire logic periph_rd_done, // Read done
    input wire logic cpu_run, // Cpu run
    input wire logic main_system_clock_en, // Sys clock
    input wire logic periph_bus_clock_en, // Pb clock
    input wire pscg_pkg::pscg_state_t power_state // State
);
    import pscg_pkg::*;
    // ****
    // Power state checks
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic hi;
    assign hi = irq_valid && (irq_prio > cpu_prio);
    sequence s_wait_taken; power_state == PSCG_RUN && wait_exec; endsequence
    sequence s_halted; power_state inside {PSCG_IDLE, PSCG_SLEEP}; endsequence
    property p_wait_enter; s_wait_taken |=> s_halted; endproperty
    a_wait_enter: assert property (p_wait_enter) else $error("wait did not halt");
    property p_idle_run;
        power_state == PSCG_IDLE && $past(power_state) == PSCG_IDLE
            |-> !cpu_run && main_system_clock_en;
    endproperty
    a_idle_run: assert property (p_idle_run) else $error("idle clocks wrong");
    property p_idle_wake; power_state == PSCG_IDLE && hi |=> power_state == PSCG_RUN; endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle missed wake");
    property p_idle_stay;
        power_state == PSCG_IDLE && !hi && !watchdog_timeout |=> power_state == PSCG_IDLE;
    endproperty
    a_idle_stay: assert property (p_idle_stay) else $error("idle left early");
    property p_idle_wdt;
        power_state == PSCG_IDLE && watchdog_timeout |=> power_state == PSCG_RUN;
    endproperty
    a_idle_wdt: assert property (p_idle_wdt) else $error("watchdog kept idle");
    property p_sleep_low;
        power_state == PSCG_SLEEP && irq_valid && irq_sleep_capable && !hi
            && !watchdog_timeout && !osc_needs_startup |=> power_state == PSCG_IDLE;
    endproperty
    a_sleep_low: assert property (p_sleep_low) else $error("low wake not idle");
    property p_sleep_hi;
        power_state == PSCG_SLEEP && irq_sleep_capable && hi && !osc_needs_startup
            |=> power_state == PSCG_RUN;
    endproperty
    a_sleep_hi: assert property (p_sleep_hi) else $error("high wake not run");
    sequence s_start2; power_state == PSCG_START ##1 power_state == PSCG_START; endsequence
    property p_startup;
        power_state == PSCG_SLEEP && watchdog_timeout && osc_needs_startup |=> s_start2;
    endproperty
    a_startup: assert property (p_startup) else $error("no start-up delay");
    property p_sleep_clk;
        power_state == PSCG_SLEEP |-> !main_system_clock_en && !periph_bus_clock_en;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("clock runs in sleep");
    property p_rd_done; periph_rd_done |-> periph_bus_clock_en && cpu_run; endproperty
    a_rd_done: assert property (p_rd_done) else $error("read off pb edge");
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
endmodule
bind pscg_top pscg_properties #(.STARTUP_CYC(STARTUP_CYC)) i_pscg_properties (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
    .wait_exec(wait_exec), .irq_valid(irq_valid), .irq_sleep_capable(irq_sleep_capable),
    .irq_prio(irq_prio), .cpu_prio(cpu_prio), .watchdog_timeout(watchdog_timeout),
    .osc_needs_startup(osc_needs_startup), .periph_rd_done(periph_rd_done),
    .cpu_run(cpu_run), .main_system_clock_en(main_system_clock_en),
    .periph_bus_clock_en(periph_bus_clock_en), .power_state(power_state));
`default_nettype wire

// *** test/pscg_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module pscg_top_tb;
    import pscg_pkg::*;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wait_exec = 0;
    logic irq_valid = 0, irq_sleep_capable = 0, watchdog_timeout = 0, osc_needs_startup = 0;
    logic periph_rd_req = 0, pready, pslverr, periph_rd_done, cpu_run, main_system_clock_en;
    logic periph_bus_clock_en;
    logic [2:0] irq_prio = 0, cpu_prio = 3;
    logic [31:0] paddr = 0, pwdata = 0, stop_in_idle = 0, prdata, q;
    logic [31:0] periph_clk_en [PSCG_NUM_MD];
    pscg_state_t power_state;
    int num_errors = 0, n_tests = 0;
    localparam logic [15:0] BASES [6] = '{PSCG_MD_ANALOG_OFS, PSCG_MD_CMP_OFS,
        PSCG_MD_CAPCMP_OFS, PSCG_MD_TIMERS_OFS, PSCG_MD_SERIAL_OFS, PSCG_MD_MISC_OFS};
    localparam logic [31:0] MASKS [6] = '{PSCG_MASK_ANALOG, PSCG_MASK_CMP,
        PSCG_MASK_CAPCMP, PSCG_MASK_TIMERS, PSCG_MASK_SERIAL, PSCG_MASK_MISC};
    pscg_top #(.STARTUP_CYC(4)) i_pscg_top (.clk(clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wait_exec(wait_exec), .irq_valid(irq_valid),
        .irq_sleep_capable(irq_sleep_capable), .irq_prio(irq_prio), .cpu_prio(cpu_prio),
        .watchdog_timeout(watchdog_timeout), .osc_needs_startup(osc_needs_startup),
        .stop_in_idle(stop_in_idle), .periph_rd_req(periph_rd_req),
        .periph_rd_done(periph_rd_done), .cpu_run(cpu_run),
        .main_system_clock_en(main_system_clock_en),
        .periph_bus_clock_en(periph_bus_clock_en), .periph_clk_en(periph_clk_en),
        .power_state(power_state));
    always #20 clk = ~clk;
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, {16'h0, a}, d, q, e);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        logic e;
        apb(1'b0, {16'h0, a}, 32'h0, q, e);
        chk(q, exp);
    endtask
    task automatic pb;
        do @(posedge clk); while (periph_bus_clock_en !== 1'b1);
    endtask
    task automatic enter(input logic [31:0] osc);
        wr(PSCG_OSC_CTRL_OFS, osc);
        wait_exec <= 1'b1;
        @(posedge clk);
        wait_exec <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic ev(input logic v, input logic wd, input logic ns, input logic [2:0] p,
                      input logic [31:0] exp);
        irq_valid <= v;
        watchdog_timeout <= wd;
        osc_needs_startup <= ns;
        irq_prio <= p;
        @(posedge clk);
        irq_valid <= 1'b0;
        watchdog_timeout <= 1'b0;
        @(posedge clk);
        chk(32'(power_state), exp);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs;
        logic e;
        for (int i = 0; i < 6; i++) begin
            rd(BASES[i], 32'h0);
            wr(BASES[i], 32'hFFFFFFFF);
            rd(BASES[i], MASKS[i]);
            pb();
            chk(periph_clk_en[i], 32'h0);
            wr(BASES[i] + 16'h4, 32'h00000001);
            rd(BASES[i], MASKS[i] & ~32'h1);
            wr(BASES[i] + 16'h8, 32'hFFFFFFFF);
            rd(BASES[i], MASKS[i]);
            wr(BASES[i] + 16'hC, 32'hFFFFFFFF);
            rd(BASES[i], 32'h0);
            pb();
            chk(periph_clk_en[i], MASKS[i]);
        end
        apb(1'b0, 32'h0000F300, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        $display("t_regs done");
    endtask
    task automatic t_div;
        int n;
        periph_rd_req <= 1'b1;
        for (int d = 0; d < 4; d++) begin
            wr(PSCG_OSC_CTRL_OFS, 32'(d) << 19);
            pb();
            pb();
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (periph_bus_clock_en !== 1'b1);
            chk(32'(n), 32'(1 << d));
            chk({31'h0, periph_rd_done}, 32'h1);
            chk({31'h0, main_system_clock_en}, 32'h1);
        end
        periph_rd_req <= 1'b0;
        $display("t_div done");
    endtask
    task automatic t_idle;
        stop_in_idle <= 32'h00000001;
        enter(32'h0);
        chk(32'(power_state), 32'(PSCG_IDLE));
        chk({30'h0, cpu_run, main_system_clock_en}, 32'h1);
        rd(PSCG_STATUS_OFS, 32'(PSCG_IDLE));
        pb();
        chk(periph_clk_en[0], PSCG_MASK_ANALOG & ~32'h1);
        ev(1'b1, 1'b0, 1'b0, 3'h3, 32'(PSCG_IDLE));
        ev(1'b1, 1'b0, 1'b0, 3'h4, 32'(PSCG_RUN));
        enter(32'h0);
        ev(1'b0, 1'b1, 1'b0, 3'h0, 32'(PSCG_RUN));
        stop_in_idle <= 32'h0;
        $display("t_idle done");
    endtask
    task automatic t_sleep;
        irq_sleep_capable <= 1'b1;
        enter(32'h10);
        chk(32'(power_state), 32'(PSCG_SLEEP));
        chk({31'h0, main_system_clock_en}, 32'h0);
        ev(1'b1, 1'b0, 1'b0, 3'h2, 32'(PSCG_IDLE));
        ev(1'b1, 1'b0, 1'b0, 3'h7, 32'(PSCG_RUN));
        enter(32'h10);
        ev(1'b1, 1'b0, 1'b0, 3'h7, 32'(PSCG_RUN));
        enter(32'h10);
        ev(1'b1, 1'b0, 1'b1, 3'h7, 32'(PSCG_START));
        repeat (6) @(posedge clk);
        chk(32'(power_state), 32'(PSCG_RUN));
        enter(32'h10);
        ev(1'b0, 1'b1, 1'b1, 3'h0, 32'(PSCG_START));
        repeat (6) @(posedge clk);
        chk(32'(power_state), 32'(PSCG_RUN));
        enter(32'h10);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'(power_state), 32'(PSCG_RUN));
        $display("t_sleep done");
    endtask
    task automatic summarize;
        $display("Tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_div();
        t_idle();
        t_sleep();
        summarize();
    end
    initial begin
        #800000;
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
